/* core/lgp_gpio.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "lgp_map.svh"
// Contract
// - Low colour inputs become pins in 18-bit mode
// - Mode register value selects 18-bit colour mode
// - Pin 3 low-nibble code picks direction
// - Pins 2 and 1 share one register
// - Pin 0 full-byte code picks direction
// - Outputs 4 to 8 follow registers only
// - Register drives outputs 8 and 7
// - Outputs 6, 5 alike; output 4 upper nibble
module lgp_gpio (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] red_low_in,
  input wire logic [1:0] green_low_in,
  output logic [3:0] gpio_fwd_data,
  output logic [3:0] gpio_fwd_valid,
  input wire logic [3:0] gpio_back_data,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  output logic [1:0] red_low_video,
  output logic [1:0] green_low_video,
  output logic mode_18bit,
  output logic [4:0] register_driven_outputs
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] pin0_config_r, pin0_config_nxt;
  logic [7:0] pin2_pin1_config_r, pin2_pin1_config_nxt;
  logic [7:0] pin3_out4_config_r, pin3_out4_config_nxt;
  logic [7:0] out6_out5_config_r, out6_out5_config_nxt;
  logic [7:0] out8_out7_config_r, out8_out7_config_nxt;
  logic [7:0] colour_mode_config_r, colour_mode_config_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [4:0] gpo_r, gpo_nxt;
  logic [3:0] fwd_r, fwd_nxt;
  logic [3:0] fwd_vld_r, fwd_vld_nxt;
  logic [3:0] out_r, out_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic [1:0] red_vid_r, red_vid_nxt;
  logic [1:0] grn_vid_r, grn_vid_nxt;
  logic [3:0] pins_sync;
  logic [3:0] back_sync;
  lgp_pkg::lgp_dir_t dir [4];
  lgp_pkg::lgp_out_t ocode [5];
  logic mode_r, mode_nxt;
  logic mode_on;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Pins arrive from outside the clock domain, so a level is taken only
  // once two late stages agree and a metastable sample never leaks out.
  lgp_sync #(.WIDTH(4)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({green_low_in, red_low_in}),
    .dout(pins_sync)
  );

  // Back-channel levels arrive from the link receiver, also unrelated.
  // A bit that keeps changing is held at its last settled level.
  lgp_sync #(.WIDTH(4)) u_back_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(gpio_back_data),
    .dout(back_sync)
  );

  // ----------------------------------------------------------------
  // Decoding of the stored codes
  // ----------------------------------------------------------------
  // Turns one nibble into a pin direction.
  function automatic lgp_pkg::lgp_dir_t nib_dir(input logic [3:0] n);
    lgp_pkg::lgp_dir_t d;
    d = lgp_pkg::LGP_DIR_OFF;
    if (n == `LGP_NIB_FWD) begin
      d = lgp_pkg::LGP_DIR_FWD;
    end else if (n == `LGP_NIB_BACK) begin
      d = lgp_pkg::LGP_DIR_BACK;
    end
    return d;
  endfunction : nib_dir

  // Turns one nibble into an output level command.
  function automatic lgp_pkg::lgp_out_t nib_out(input logic [3:0] n);
    lgp_pkg::lgp_out_t o;
    o = lgp_pkg::LGP_OUT_HOLD;
    if (n == `LGP_NIB_OUT_HI) begin
      o = lgp_pkg::LGP_OUT_HIGH;
    end else if (n == `LGP_NIB_OUT_LO) begin
      o = lgp_pkg::LGP_OUT_LOW;
    end
    return o;
  endfunction : nib_out

  // Mode decode and per-pin direction decode.
  always_comb begin
    mode_on = mode_r;
    dir[3] = nib_dir(pin3_out4_config_r[3:0]);
    dir[2] = nib_dir(pin2_pin1_config_r[7:4]);
    dir[1] = nib_dir(pin2_pin1_config_r[3:0]);
    // Pin 0 needs the whole byte, upper nibble included.
    // Any other upper nibble leaves the pin with its video function.
    dir[0] = lgp_pkg::LGP_DIR_OFF;
    if (pin0_config_r[7:4] == `LGP_PIN0_HI_NIB) begin
      dir[0] = nib_dir(pin0_config_r[3:0]);
    end
  end

  // Output-code decode, one nibble for each register-driven output.
  always_comb begin
    ocode[4] = nib_out(out8_out7_config_r[7:4]);
    ocode[3] = nib_out(out8_out7_config_r[3:0]);
    ocode[2] = nib_out(out6_out5_config_r[7:4]);
    ocode[1] = nib_out(out6_out5_config_r[3:0]);
    ocode[0] = nib_out(pin3_out4_config_r[7:4]);
  end

  // ----------------------------------------------------------------
  // Pin datapath
  // ----------------------------------------------------------------
  // Each pin is borrowed from video only in 18-bit mode when enabled.
  // Outside that mode every pin is released and its output enable is low.
  always_comb begin
    fwd_nxt = '0;
    fwd_vld_nxt = '0;
    out_nxt = '0;
    oe_nxt = '0;
    for (int i = 0; i < 4; i++) begin
      if (mode_on && dir[i] == lgp_pkg::LGP_DIR_FWD) begin
        fwd_nxt[i] = pins_sync[i];
        fwd_vld_nxt[i] = 1'b1;
      end else if (mode_on && dir[i] == lgp_pkg::LGP_DIR_BACK) begin
        out_nxt[i] = back_sync[i];
        oe_nxt[i] = 1'b1;
      end
    end
  end

  // Video sees zero on a borrowed bit and the pin level otherwise, so
  // the panel never shows a general-purpose level as colour.
  always_comb begin
    red_vid_nxt = pins_sync[1:0] & ~(fwd_vld_nxt[1:0] | oe_nxt[1:0]);
    grn_vid_nxt = pins_sync[3:2] & ~(fwd_vld_nxt[3:2] | oe_nxt[3:2]);
  end

  // Register-driven outputs change only on a high or low code.
  // Other nibble values hold the level, so a shared byte can be rewritten
  // without disturbing the output that sits in its other half.
  always_comb begin
    gpo_nxt = gpo_r;
    for (int i = 0; i < 5; i++) begin
      if (ocode[i] == lgp_pkg::LGP_OUT_HIGH) begin
        gpo_nxt[i] = 1'b1;
      end else if (ocode[i] == lgp_pkg::LGP_OUT_LOW) begin
        gpo_nxt[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  // Writes store the whole byte; reads return data one cycle later.
  always_comb begin
    pin0_config_nxt = pin0_config_r;
    pin2_pin1_config_nxt = pin2_pin1_config_r;
    pin3_out4_config_nxt = pin3_out4_config_r;
    out6_out5_config_nxt = out6_out5_config_r;
    out8_out7_config_nxt = out8_out7_config_r;
    colour_mode_config_nxt = colour_mode_config_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `LGP_OFF_PIN0: pin0_config_nxt = reg_wdata;
        `LGP_OFF_PIN21: pin2_pin1_config_nxt = reg_wdata;
        `LGP_OFF_PIN3_OUT4: pin3_out4_config_nxt = reg_wdata;
        `LGP_OFF_OUT65: out6_out5_config_nxt = reg_wdata;
        `LGP_OFF_OUT87: out8_out7_config_nxt = reg_wdata;
        `LGP_OFF_MODE: colour_mode_config_nxt = reg_wdata;
        default: begin
        end
      endcase
    end
    // The mode flag follows the value the register is about to hold, so
    // it changes in the same cycle as the register; the pins follow one cycle later.
    mode_nxt = (colour_mode_config_nxt == `LGP_MODE_18BIT);
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Only a read strobe loads the addressed byte; other cycles give zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `LGP_OFF_PIN0: rdata_nxt = pin0_config_r;
        `LGP_OFF_PIN21: rdata_nxt = pin2_pin1_config_r;
        `LGP_OFF_PIN3_OUT4: rdata_nxt = pin3_out4_config_r;
        `LGP_OFF_OUT65: rdata_nxt = out6_out5_config_r;
        `LGP_OFF_OUT87: rdata_nxt = out8_out7_config_r;
        `LGP_OFF_MODE: rdata_nxt = colour_mode_config_r;
        `LGP_OFF_STATUS: rdata_nxt = {3'h0, gpo_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  // Configuration bytes and the mode flag, cleared by reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin0_config_r <= `LGP_RST_CFG;
      pin2_pin1_config_r <= `LGP_RST_CFG;
      pin3_out4_config_r <= `LGP_RST_CFG;
      out6_out5_config_r <= `LGP_RST_CFG;
      out8_out7_config_r <= `LGP_RST_CFG;
      colour_mode_config_r <= `LGP_RST_CFG;
      mode_r <= `LGP_RST_FLAG;
    end else begin
      pin0_config_r <= pin0_config_nxt;
      pin2_pin1_config_r <= pin2_pin1_config_nxt;
      pin3_out4_config_r <= pin3_out4_config_nxt;
      out6_out5_config_r <= out6_out5_config_nxt;
      out8_out7_config_r <= out8_out7_config_nxt;
      colour_mode_config_r <= colour_mode_config_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Read data stands for one cycle and then falls back to zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= `LGP_RST_CFG;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Datapath state
  // ----------------------------------------------------------------
  // Register-driven output levels.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpo_r <= `LGP_RST_GPO;
    end else begin
      gpo_r <= gpo_nxt;
    end
  end

  // Pin drive and forward data.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fwd_r <= `LGP_RST_PIN;
      fwd_vld_r <= `LGP_RST_PIN;
      out_r <= `LGP_RST_PIN;
      oe_r <= `LGP_RST_PIN;
    end else begin
      fwd_r <= fwd_nxt;
      fwd_vld_r <= fwd_vld_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Video bits towards the serializer.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      red_vid_r <= `LGP_RST_VID;
      grn_vid_r <= `LGP_RST_VID;
    end else begin
      red_vid_r <= red_vid_nxt;
      grn_vid_r <= grn_vid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Everything leaves from flip-flops.
  assign reg_rdata = rdata_r;
  assign gpio_fwd_data = fwd_r;
  assign gpio_fwd_valid = fwd_vld_r;
  assign gpio_out = out_r;
  assign gpio_oe = oe_r;
  assign red_low_video = red_vid_r;
  assign green_low_video = grn_vid_r;
  assign mode_18bit = mode_r;
  assign register_driven_outputs = gpo_r;
endmodule : lgp_gpio

/* core/lgp_map.svh */
`ifndef LGP_MAP_SVH
`define LGP_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LGP_ADDR_W 8
`define LGP_OFF_PIN0 8'h0D
`define LGP_OFF_PIN21 8'h0E
`define LGP_OFF_PIN3_OUT4 8'h0F
`define LGP_OFF_OUT65 8'h10
`define LGP_OFF_OUT87 8'h11
`define LGP_OFF_MODE 8'h12
`define LGP_OFF_STATUS 8'h13
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define LGP_RST_CFG 8'h00
`define LGP_RST_FLAG 1'b0
`define LGP_RST_GPO 5'h00
`define LGP_RST_PIN 4'h0
`define LGP_RST_VID 2'h0
`define LGP_MODE_18BIT 8'h04
`define LGP_NIB_FWD 4'h3
`define LGP_NIB_BACK 4'h5
`define LGP_NIB_OUT_HI 4'h9
`define LGP_NIB_OUT_LO 4'h1
`define LGP_PIN0_HI_NIB 4'h9
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LGP_NIB_HI_MSB 7
`define LGP_NIB_HI_LSB 4
`define LGP_NIB_LO_MSB 3
`define LGP_NIB_LO_LSB 0
`endif

/* core/lgp_pkg.sv */
package lgp_pkg;
  // Direction chosen for one general-purpose pin.
  typedef enum logic [1:0] {
    LGP_DIR_OFF,
    LGP_DIR_FWD,
    LGP_DIR_BACK
  } lgp_dir_t;
  // Level chosen for one register-driven output.
  typedef enum logic [1:0] {
    LGP_OUT_HOLD,
    LGP_OUT_HIGH,
    LGP_OUT_LOW
  } lgp_out_t;
endpackage : lgp_pkg

/* core/lgp_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------
module lgp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, dout_r;
  logic [WIDTH-1:0] dout_nxt;

  // The output follows only where stages two and three agree.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      dout_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : dout_r[i];
    end
  end

  // The first stage feeds only the second.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;
endmodule : lgp_sync

/* tb/lgp_gpio_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the pin and output logic
// ----------------------------------------
module lgp_gpio_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] gpio_fwd_valid,
  input wire logic [3:0] gpio_oe,
  input wire logic mode_18bit,
  input wire logic [4:0] register_driven_outputs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A write whose masked data equals the given code.
  sequence s_wr(a, m, v);
    reg_wr && reg_addr == a && (reg_wdata & m) == v;
  endsequence
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  chk_mode_decode: assert property (
    reg_wr && reg_addr == 8'h12 |=> mode_18bit == ($past(reg_wdata) == 8'h04))
    else $error("colour mode decode wrong");
  chk_out8_high: assert property (
    s_wr(8'h11, 8'hF0, 8'h90) |=> ##1 register_driven_outputs[4])
    else $error("output 8 not high");
  chk_out7_low: assert property (
    s_wr(8'h11, 8'h0F, 8'h01) |-> ##2 !register_driven_outputs[3])
    else $error("output 7 not low");
  chk_out4_high: assert property (
    s_wr(8'h0F, 8'hF0, 8'h90) |-> ##2 register_driven_outputs[0])
    else $error("output 4 not high");
  chk_pins_off: assert property (
    !mode_18bit [*2] |-> gpio_oe == 4'h0 && gpio_fwd_valid == 4'h0)
    else $error("pins active outside colour mode");
  chk_pin3_back: assert property (
    s_wr(8'h0F, 8'h0F, 8'h05) ##0 mode_18bit |=> ##1 gpio_oe[3]
    && !gpio_fwd_valid[3]) else $error("pin 3 not back output");
  chk_pin2_fwd: assert property (
    s_wr(8'h0E, 8'hF0, 8'h30) ##0 mode_18bit |-> ##2 gpio_fwd_valid[2]
    && !gpio_oe[2]) else $error("pin 2 not forward input");
  chk_pin0_fwd: assert property (
    s_wr(8'h0D, 8'hFF, 8'h93) ##0 mode_18bit |-> ##2 gpio_fwd_valid[0])
    else $error("pin 0 not forward input");
  chk_status_read: assert property (
    reg_rd && reg_addr == 8'h13 |=> reg_rdata ==
    {3'b000, $past(register_driven_outputs)}) else $error("status read wrong");
endmodule : lgp_gpio_chk

bind lgp_gpio lgp_gpio_chk u_lgp_gpio_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_fwd_valid(gpio_fwd_valid),
  .gpio_oe(gpio_oe), .mode_18bit(mode_18bit),
  .register_driven_outputs(register_driven_outputs));

/* tb/lgp_remote.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Remote deserializer pin model
// ----------------------------------------
module lgp_remote (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] remote_fwd,
  input wire logic [3:0] remote_pin,
  input wire logic [3:0] fwd_data,
  input wire logic [3:0] fwd_valid,
  output logic [3:0] back_data,
  output logic [3:0] remote_out
);
  // Mirrored inputs send their level back; undriven bits keep toggling.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      back_data <= 4'h0;
      remote_out <= 4'h0;
    end else begin
      back_data <= (remote_fwd & remote_pin) | (~remote_fwd & ~back_data);
      remote_out <= fwd_data & fwd_valid;
    end
  end
endmodule : lgp_remote

/* tb/lgp_gpio_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
// ----------------------------------------
// Testbench of the pin and output logic
// ----------------------------------------
module lgp_gpio_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [3:0] rem_fwd = 4'h0;
  logic [3:0] rem_pin = 4'h0;
  logic [7:0] reg_rdata, oa, hi;
  logic [3:0] fwd_data, fwd_valid, back_data, gpio_out, gpio_oe, rem_out;
  logic [1:0] red_video, green_video;
  logic mode_18bit;
  logic [4:0] reg_outs;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] cfg_addr [4] = '{8'h0D, 8'h0E, 8'h0E, 8'h0F};
  logic [7:0] cfg_fwd [4] = '{8'h93, 8'h03, 8'h30, 8'h03};
  logic [7:0] cfg_back [4] = '{8'h95, 8'h05, 8'h50, 8'h05};

  // Clock with an 8 ns period.
  always #4 sys_clk = ~sys_clk;

  lgp_gpio u_lgp_gpio (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .red_low_in(pins[1:0]),
    .green_low_in(pins[3:2]), .gpio_fwd_data(fwd_data),
    .gpio_fwd_valid(fwd_valid), .gpio_back_data(back_data),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .red_low_video(red_video),
    .green_low_video(green_video), .mode_18bit(mode_18bit),
    .register_driven_outputs(reg_outs));

  lgp_remote u_lgp_remote (.sys_clk(sys_clk), .rst(rst),
    .remote_fwd(rem_fwd), .remote_pin(rem_pin), .fwd_data(fwd_data),
    .fwd_valid(fwd_valid), .back_data(back_data), .remote_out(rem_out));

  // One register write cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One register read cycle; data is checked in the cycle after it.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("read data", e, reg_rdata)
  endtask : rd

  // Let n edges pass, then step off the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Print the counts and the verdict, then stop.
  task automatic results;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Cut a hung run short.
  initial begin
    #100000;
    error_cnt++;
    results();
  end

  // Registers, pin directions, then register-driven outputs.
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 8'h0D; a <= 8'h13; a++) begin
      rd(8'(a), 8'h00);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h0E, 8'h35);
    rd(8'h0E, 8'h35);
    wr(8'h12, 8'h04);
    rd(8'h12, 8'h04);
    `CHK("mode on", 1'b1, mode_18bit)
    for (int i = 0; i < 4; i++) begin
      wr(cfg_addr[i], cfg_fwd[i]);
      rem_fwd <= 4'h0;
      pins <= 4'h1 << i;
      cyc(7);
      `CHK("fwd valid", 1'b1, fwd_valid[i])
      `CHK("oe fwd", 1'b0, gpio_oe[i])
      `CHK("remote out", 1'b1, rem_out[i])
      `CHK("video", 4'h0, {green_video, red_video})
      wr(cfg_addr[i], cfg_back[i]);
      rem_fwd <= 4'h1 << i;
      rem_pin <= 4'hF;
      cyc(8);
      `CHK("oe back", 1'b1, gpio_oe[i])
      `CHK("pin out", 1'b1, gpio_out[i])
    end
    wr(8'h0D, 8'h03);
    cyc(2);
    `CHK("pin0 off", 2'b00, {fwd_valid[0], gpio_oe[0]})
    wr(8'h12, 8'h05);
    pins <= 4'hA;
    cyc(7);
    `CHK("mode off", 1'b0, mode_18bit)
    `CHK("oe off", 4'h0, gpio_oe)
    `CHK("valid off", 4'h0, fwd_valid)
    `CHK("video", 4'hA, {green_video, red_video})
    for (int k = 0; k < 5; k++) begin
      oa = 8'h0F + 8'((k + 1) / 2);
      hi = (k % 2 == 1) ? 8'h09 : 8'h90;
      wr(oa, hi);
      cyc(2);
      `CHK("out high", 1'b1, reg_outs[k])
      rd(8'h13, 8'h01 << k);
      wr(oa, 8'h00);
      cyc(2);
      `CHK("out hold", 1'b1, reg_outs[k])
      wr(oa, hi & 8'h11);
      cyc(2);
      `CHK("out low", 1'b0, reg_outs[k])
    end
    results();
  end
endmodule : lgp_gpio_tb
